//--- pkg/reset_ctrl_pkg.sv
// Package: register map, codes, timing and carrier types of the reset source controller
package reset_ctrl_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_CTRL_WORD = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_LVSEL = 8'h08;
  localparam logic [7:0] ADDR_WDTEN = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // ------------------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_IO = 8'h55;
  localparam logic [7:0] CTRL_PIN = 8'hAA;
  localparam logic [7:0] CTRL_POR = 8'h55;
  localparam logic [7:0] LVS_2V10 = 8'h55;
  localparam logic [7:0] LVS_2V55 = 8'h33;
  localparam logic [7:0] LVS_3V15 = 8'h99;
  localparam logic [7:0] LVS_3V80 = 8'hAA;
  localparam logic [7:0] LVS_POR = 8'h55;
  localparam logic [4:0] WDT_EN = 5'h0A;
  localparam logic [4:0] WDT_DIS = 5'h15;
  localparam logic [4:0] WDT_POR = 5'h0A;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FLAGS_W = 4;
  localparam int FLG_WDT = 0;
  localparam int FLG_LVS = 1;
  localparam int FLG_LVR = 2;
  localparam int FLG_CTRL = 3;
  localparam int ST_TO = 0;
  localparam int ST_PDF = 1;
  localparam logic [3:0] FLAGS_POR = 4'h0;
  localparam logic [3:0] MASK_POR = 4'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CORRUPT_DELAY_NS = 1000;
  localparam int LV_FILTER_NS = 2000;
  localparam int CORRUPT_DELAY_CYC = (CORRUPT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LV_FILTER_CYC = (LV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] RST_HOLD_CYC = 3'h4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LV_2V10 = 2'h0,
    LV_2V55 = 2'h1,
    LV_3V15 = 2'h2,
    LV_3V80 = 2'h3
  } lv_level_t;

  typedef struct packed {
    logic valid;
    lv_level_t level;
  } lv_dec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pc_zero;
    logic int_disable;
    logic wdt_tb_clear;
    logic timers_off;
    logic ports_input;
    logic sp_top;
  } init_ctl_t;

endpackage : reset_ctrl_pkg

//--- hdl/cycle_delay.sv
// Module: qualifying counter that fires once after an input has stood for a set count
`timescale 1ns/1ps
module cycle_delay #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Qualify
  input wire logic arm_i,
  output logic fire_o
);
  import reset_ctrl_pkg::*;

  localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic fire_d;

  // ------------------------------------------------------------
  // Count while armed, saturate at the limit
  // ------------------------------------------------------------
  assign cnt_d = !arm_i ? '0 : ((cnt_q == LIM) ? cnt_q : cnt_q + ONE);
  assign fire_d = arm_i && (cnt_q == LIM - ONE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      fire_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fire_o <= fire_d;
    end
  end

endmodule : cycle_delay

//--- hdl/reset_source_control.sv
// Module: reset source supervision, cause flags and APB registers
`timescale 1ns/1ps
module reset_source_control #(
  parameter int unsigned CORRUPT_CYC = reset_ctrl_pkg::CORRUPT_DELAY_CYC,
  parameter int unsigned LV_FILT_CYC = reset_ctrl_pkg::LV_FILTER_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire reset_ctrl_pkg::apb_req_t APB_REQ_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Reset sources
  input wire logic RESET_PIN_N_I,
  input wire logic LV_DETECT_I,
  input wire logic WDT_TIMEOUT_I,
  // Core activity
  input wire logic POWER_DOWN_I,
  input wire logic SLEEP_ENTRY_I,
  input wire logic WDT_CLEAR_CMD_I,
  // Reset and control outputs
  output logic SYS_RST_O,
  output reset_ctrl_pkg::init_ctl_t INIT_CTL_O,
  output logic PC_SP_CLEAR_O,
  output logic PIN_IS_RESET_O,
  output reset_ctrl_pkg::lv_level_t LV_LEVEL_O,
  output logic LVR_ENABLE_O,
  output logic WDT_ENABLE_O,
  // Status and interrupt
  output logic TO_FLAG_O,
  output logic PDF_FLAG_O,
  output logic IRQ_O
);
  import reset_ctrl_pkg::*;

  // ------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------
  // pin function codes
  function automatic logic ctrl_ok(input logic [7:0] c);
    ctrl_ok = (c == CTRL_IO) || (c == CTRL_PIN);
  endfunction : ctrl_ok

  function automatic lv_dec_t lv_decode(input logic [7:0] c);
    lv_dec_t r;
    r.valid = 1'b1;
    r.level = LV_2V10;
    case (c)
      LVS_2V10: r.level = LV_2V10;
      LVS_2V55: r.level = LV_2V55;
      LVS_3V15: r.level = LV_3V15;
      LVS_3V80: r.level = LV_3V80;
      default: r.valid = 1'b0;
    endcase
    lv_decode = r;
  endfunction : lv_decode

  function automatic logic wdt_ok(input logic [4:0] c);
    wdt_ok = (c == WDT_EN) || (c == WDT_DIS);
  endfunction : wdt_ok

  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction : word8

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic pin_meta_q;
  logic pin_sync_q;
  logic lv_meta_q;
  logic lv_sync_q;
  logic [7:0] ctrlw_q;
  logic [7:0] ctrlw_d;
  logic [7:0] lvsel_q;
  logic [7:0] lvsel_d;
  logic [4:0] wdten_q;
  logic [4:0] wdten_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] flags_set;
  logic [3:0] flags_clr;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic to_q;
  logic to_d;
  logic pdf_q;
  logic pdf_d;
  logic [2:0] hold_q;
  logic [2:0] hold_d;
  logic sys_rst_q;
  logic pcsp_q;
  logic pin_rst_fn_q;
  lv_level_t lv_level_q;
  lv_level_t lv_level_d;
  logic lvr_en_q;
  logic wdt_en_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  lv_dec_t lv_dec;
  logic setup_w;
  logic wr_w;
  logic hit_ctrl;
  logic hit_flags;
  logic hit_lvsel;
  logic hit_wdten;
  logic hit_status;
  logic hit_mask;
  logic mapped_w;
  logic [31:0] rdata_w;
  logic ctrl_arm;
  logic lvs_arm;
  logic wdt_arm;
  logic lv_arm;
  logic ctrl_fire;
  logic lvs_fire;
  logic wdt_fire;
  logic lv_fire;
  logic pin_rst_w;
  logic wdt_run_w;
  logic wdt_sleep_w;
  logic trigger_w;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      lv_meta_q <= 1'b0;
      lv_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= RESET_PIN_N_I;
      pin_sync_q <= pin_meta_q;
      lv_meta_q <= LV_DETECT_I;
      lv_sync_q <= lv_meta_q;
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign setup_w = APB_REQ_I.psel & ~APB_REQ_I.penable;
  assign wr_w = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite & pready_q;
  assign hit_ctrl = APB_REQ_I.paddr == ADDR_CTRL_WORD;
  assign hit_flags = APB_REQ_I.paddr == ADDR_FLAGS;
  assign hit_lvsel = APB_REQ_I.paddr == ADDR_LVSEL;
  assign hit_wdten = APB_REQ_I.paddr == ADDR_WDTEN;
  assign hit_status = APB_REQ_I.paddr == ADDR_STATUS;
  assign hit_mask = APB_REQ_I.paddr == ADDR_MASK;
  assign mapped_w = hit_ctrl | hit_flags | hit_lvsel | hit_wdten | hit_status | hit_mask;

  assign rdata_w = hit_ctrl ? word8(ctrlw_q) :
                   hit_flags ? word8({4'h0, flags_q}) :
                   hit_lvsel ? word8(lvsel_q) :
                   hit_wdten ? word8({3'h0, wdten_q}) :
                   hit_status ? word8({6'h00, pdf_q, to_q}) :
                   hit_mask ? word8({4'h0, mask_q}) : 32'h00000000;

  // ------------------------------------------------------------
  // Reset sources
  // ------------------------------------------------------------
  assign lv_dec = lv_decode(lvsel_q);
  assign ctrl_arm = ~ctrl_ok(ctrlw_q) & ~sys_rst_q;
  assign lvs_arm = ~lv_dec.valid & ~sys_rst_q;
  assign wdt_arm = ~wdt_ok(wdten_q) & ~sys_rst_q;
  assign lv_arm = lv_sync_q & ~POWER_DOWN_I & ~sys_rst_q;
  assign pin_rst_w = (ctrlw_q == CTRL_PIN) & ~pin_sync_q;
  assign wdt_run_w = WDT_TIMEOUT_I & ~POWER_DOWN_I;
  assign wdt_sleep_w = WDT_TIMEOUT_I & POWER_DOWN_I;
  assign trigger_w = ctrl_fire | lvs_fire | wdt_fire | lv_fire | pin_rst_w | wdt_run_w;

  cycle_delay #(.LIMIT(CORRUPT_CYC)) u_ctrl_delay (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .arm_i(ctrl_arm),
    .fire_o(ctrl_fire)
  );

  cycle_delay #(.LIMIT(CORRUPT_CYC)) u_lvs_delay (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .arm_i(lvs_arm),
    .fire_o(lvs_fire)
  );

  cycle_delay #(.LIMIT(CORRUPT_CYC)) u_wdt_delay (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .arm_i(wdt_arm),
    .fire_o(wdt_fire)
  );

  cycle_delay #(.LIMIT(LV_FILT_CYC + 1)) u_lv_filter (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .arm_i(lv_arm),
    .fire_o(lv_fire)
  );

  // ------------------------------------------------------------
  // Register next values
  // ------------------------------------------------------------
  // control word back to its reset value
  assign ctrlw_d = trigger_w ? CTRL_POR : ((wr_w & hit_ctrl) ? APB_REQ_I.pwdata[7:0] : ctrlw_q);
  assign lvsel_d = lvs_fire ? LVS_POR : ((wr_w & hit_lvsel) ? APB_REQ_I.pwdata[7:0] : lvsel_q);
  assign wdten_d = trigger_w ? WDT_POR : ((wr_w & hit_wdten) ? APB_REQ_I.pwdata[4:0] : wdten_q);
  assign mask_d = (wr_w & hit_mask) ? APB_REQ_I.pwdata[3:0] : mask_q;

  assign flags_set[FLG_CTRL] = ctrl_fire;
  assign flags_set[FLG_LVR] = lv_fire;
  assign flags_set[FLG_LVS] = lvs_fire;
  assign flags_set[FLG_WDT] = wdt_fire;
  assign flags_clr = (wr_w & hit_flags) ? APB_REQ_I.pwdata[3:0] : 4'h0;
  assign flags_d = (flags_q & ~flags_clr) | flags_set;

  // time-out set by any watchdog time-out
  assign to_d = WDT_TIMEOUT_I ? 1'b1 : ((SLEEP_ENTRY_I | WDT_CLEAR_CMD_I) ? 1'b0 : to_q);
  assign pdf_d = (wdt_sleep_w | SLEEP_ENTRY_I) ? 1'b1 : (WDT_CLEAR_CMD_I ? 1'b0 : pdf_q);

  assign hold_d = trigger_w ? RST_HOLD_CYC : ((hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0);
  assign lv_level_d = lv_dec.valid ? lv_dec.level : lv_level_q;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrlw_q <= CTRL_POR;
      lvsel_q <= LVS_POR;
      wdten_q <= WDT_POR;
      flags_q <= FLAGS_POR;
      mask_q <= MASK_POR;
      to_q <= 1'b0;
      pdf_q <= 1'b0;
    end else begin
      ctrlw_q <= ctrlw_d;
      lvsel_q <= lvsel_d;
      wdten_q <= wdten_d;
      flags_q <= flags_d;
      mask_q <= mask_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
    end
  end

  // ------------------------------------------------------------
  // Device reset pulse and init controls
  // ------------------------------------------------------------
  // power-on starts a reset pulse
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_q <= RST_HOLD_CYC;
      sys_rst_q <= 1'b1;
      pcsp_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      sys_rst_q <= hold_d != 3'h0;
      pcsp_q <= wdt_sleep_w;
    end
  end

  // ------------------------------------------------------------
  // Output flops
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_rst_fn_q <= 1'b0;
      lv_level_q <= LV_2V10;
      lvr_en_q <= 1'b1;
      wdt_en_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      pin_rst_fn_q <= ctrlw_q == CTRL_PIN;
      lv_level_q <= lv_level_d;
      lvr_en_q <= ~POWER_DOWN_I;
      wdt_en_q <= wdten_q == WDT_EN;
      irq_q <= |(flags_q & mask_q);
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & ~mapped_w;
      if (setup_w) begin
        prdata_q <= rdata_w;
      end
    end
  end

  // ------------------------------------------------------------
  // Output drive
  // ------------------------------------------------------------
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign SYS_RST_O = sys_rst_q;
  assign INIT_CTL_O = {6{sys_rst_q}};
  assign PC_SP_CLEAR_O = pcsp_q;
  assign PIN_IS_RESET_O = pin_rst_fn_q;
  assign LV_LEVEL_O = lv_level_q;
  assign LVR_ENABLE_O = lvr_en_q;
  assign WDT_ENABLE_O = wdt_en_q;
  assign TO_FLAG_O = to_q;
  assign PDF_FLAG_O = pdf_q;
  assign IRQ_O = irq_q;

endmodule : reset_source_control

//--- tb/source_model.sv
// Partner model: reset pin, supply comparator and watchdog time-out line, each registered once
`timescale 1ns/1ps
module source_model (
  // Clock
  input wire logic clk_i,
  // Commands from the bench
  input wire logic pin_low_i,
  input wire logic lv_low_i,
  input wire logic wdt_fire_i,
  // Lines into the block
  output logic pin_n_o,
  output logic lv_o,
  output logic wdt_o
);
  initial begin
    pin_n_o = 1'b1;
    lv_o = 1'b0;
    wdt_o = 1'b0;
  end
  always @(posedge clk_i) begin
    pin_n_o <= !pin_low_i;
    lv_o <= lv_low_i;
    wdt_o <= wdt_fire_i;
  end
endmodule : source_model

//--- tb/reset_source_control_props.sv
// Checker: port relations of the reset source controller
`timescale 1ns/1ps
module reset_source_control_props
  import reset_ctrl_pkg::*;
#(
  parameter int unsigned CORRUPT_CYC = 25,
  parameter int unsigned LV_FILT_CYC = 50
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Watched ports
  input wire reset_ctrl_pkg::apb_req_t APB_REQ_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic LV_DETECT_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic POWER_DOWN_I,
  input wire logic SLEEP_ENTRY_I,
  input wire logic WDT_CLEAR_CMD_I,
  input wire logic SYS_RST_O,
  input wire reset_ctrl_pkg::init_ctl_t INIT_CTL_O,
  input wire logic PC_SP_CLEAR_O,
  input wire logic LVR_ENABLE_O,
  input wire logic TO_FLAG_O,
  input wire logic PDF_FLAG_O
);
  localparam int CR_MAX = CORRUPT_CYC + 6;
  localparam int LV_LIM = LV_FILT_CYC + 3;
  logic [15:0] lv_run_q;
  logic [15:0] lv_run_d;
  logic [7:0] wd;
  logic bad_cfg;
  assign wd = APB_REQ_I.pwdata[7:0];
  assign bad_cfg = (APB_REQ_I.paddr == ADDR_CTRL_WORD && wd != CTRL_IO && wd != CTRL_PIN)
    || (APB_REQ_I.paddr == ADDR_LVSEL && !(wd inside {LVS_2V10, LVS_2V55, LVS_3V15, LVS_3V80}))
    || (APB_REQ_I.paddr == ADDR_WDTEN && wd[4:0] != WDT_EN && wd[4:0] != WDT_DIS);
  assign lv_run_d = (LV_DETECT_I && !POWER_DOWN_I && !SYS_RST_O) ? lv_run_q + 16'h1 : 16'h0;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lv_run_q <= 16'h0;
    end else begin
      lv_run_q <= lv_run_d;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ----
  // Properties
  // ----
  sequence bad_write;
    APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite && PREADY_O && bad_cfg && !SYS_RST_O;
  endsequence
  sequence flags_read;
    APB_REQ_I.psel && APB_REQ_I.penable && !APB_REQ_I.pwrite && PREADY_O
      && APB_REQ_I.paddr == ADDR_FLAGS;
  endsequence
  a_bad_cfg_reset: assert property (bad_write |-> ##[1:CR_MAX] SYS_RST_O)
    else $error("bad config word did not reset");
  a_flags_upper: assert property (flags_read |-> PRDATA_O[31:4] == 28'h0)
    else $error("cause register upper bits not zero");
  a_init_follow: assert property (INIT_CTL_O == {6{SYS_RST_O}})
    else $error("init controls differ from reset");
  a_rst_hold: assert property ($rose(SYS_RST_O) |=> SYS_RST_O [*3])
    else $error("reset pulse too short");
  a_wdt_run: assert property (WDT_TIMEOUT_I && !POWER_DOWN_I && !SYS_RST_O
    |=> SYS_RST_O && TO_FLAG_O) else $error("run mode time-out wrong");
  a_wdt_sleep: assert property (WDT_TIMEOUT_I && POWER_DOWN_I && !SYS_RST_O
    |=> PC_SP_CLEAR_O && TO_FLAG_O && PDF_FLAG_O && !SYS_RST_O)
    else $error("sleep time-out wrong");
  a_sleep_flags: assert property (SLEEP_ENTRY_I && !WDT_TIMEOUT_I && !WDT_CLEAR_CMD_I
    |=> PDF_FLAG_O && !TO_FLAG_O) else $error("sleep entry flags wrong");
  a_clear_flags: assert property (WDT_CLEAR_CMD_I && !WDT_TIMEOUT_I && !SLEEP_ENTRY_I
    |=> !TO_FLAG_O && !PDF_FLAG_O) else $error("watchdog clear flags wrong");
  a_lvr_off: assert property (POWER_DOWN_I |=> !LVR_ENABLE_O)
    else $error("low-voltage reset enabled in power-down");
  a_lv_reset: assert property (lv_run_q == LV_LIM |-> ##[0:4] SYS_RST_O)
    else $error("held low voltage did not reset");
endmodule : reset_source_control_props

bind reset_source_control reset_source_control_props #(
  .CORRUPT_CYC(CORRUPT_CYC),
  .LV_FILT_CYC(LV_FILT_CYC)
) u_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .APB_REQ_I(APB_REQ_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .LV_DETECT_I(LV_DETECT_I), .WDT_TIMEOUT_I(WDT_TIMEOUT_I),
  .POWER_DOWN_I(POWER_DOWN_I), .SLEEP_ENTRY_I(SLEEP_ENTRY_I),
  .WDT_CLEAR_CMD_I(WDT_CLEAR_CMD_I), .SYS_RST_O(SYS_RST_O), .INIT_CTL_O(INIT_CTL_O),
  .PC_SP_CLEAR_O(PC_SP_CLEAR_O), .LVR_ENABLE_O(LVR_ENABLE_O), .TO_FLAG_O(TO_FLAG_O),
  .PDF_FLAG_O(PDF_FLAG_O)
);

//--- tb/reset_source_control_tb.sv
// Testbench: directed scenarios for the reset source controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module reset_source_control_tb;
  import reset_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, sys_rst, pc_sp, pin_is_rst, lvr_en, wdt_en, to_flag, pdf_flag, irq;
  init_ctl_t init_ctl;
  lv_level_t lv_level;
  logic pin_n, lv, wdt, pd = 1'b0, slp = 1'b0, clr = 1'b0;
  logic pin_low = 1'b0, lv_low = 1'b0, wdt_fire = 1'b0;
  int err_total = 0, comparisons = 0, cyc = 0;
  logic [7:0] lvc [4] = '{LVS_2V10, LVS_2V55, LVS_3V15, LVS_3V80};
  always #20 clk = ~clk;
  source_model u_src (.clk_i(clk), .pin_low_i(pin_low), .lv_low_i(lv_low),
    .wdt_fire_i(wdt_fire), .pin_n_o(pin_n), .lv_o(lv), .wdt_o(wdt));
  reset_source_control #(.CORRUPT_CYC(3), .LV_FILT_CYC(3)) DUT (.CORE_CLK_I(clk),
    .RST_N_I(rst_n), .APB_REQ_I(req), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .RESET_PIN_N_I(pin_n), .LV_DETECT_I(lv), .WDT_TIMEOUT_I(wdt),
    .POWER_DOWN_I(pd), .SLEEP_ENTRY_I(slp), .WDT_CLEAR_CMD_I(clr), .SYS_RST_O(sys_rst),
    .INIT_CTL_O(init_ctl), .PC_SP_CLEAR_O(pc_sp), .PIN_IS_RESET_O(pin_is_rst),
    .LV_LEVEL_O(lv_level), .LVR_ENABLE_O(lvr_en), .WDT_ENABLE_O(wdt_en),
    .TO_FLAG_O(to_flag), .PDF_FLAG_O(pdf_flag), .IRQ_O(irq));
  // ----
  // Bus and reset helpers
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(n, x, q)
  endtask : rd
  task automatic chk_rst(input int lim, input logic x);
    int n;
    logic seen = 1'b0;
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      if (sys_rst === 1'b1 && !seen) begin
        seen = 1'b1;
        pin_low <= 1'b0;
        lv_low <= 1'b0;
      end
    end
    `CHK("sys_rst", x, seen)
    while (sys_rst !== 1'b0) @(posedge clk);
  endtask : chk_rst
  // ----
  // Scenarios
  // ----
  task automatic t_por;
    logic [31:0] q;
    logic e;
    rd("ctrl_word", ADDR_CTRL_WORD, 32'h55);
    rd("flags", ADDR_FLAGS, 32'h0);
    rd("lvsel", ADDR_LVSEL, 32'h55);
    rd("wdten", ADDR_WDTEN, 32'h0A);
    rd("status", ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h18, 32'h0, q, e);
    `CHK("slverr", 1'b1, e)
    `CHK("init_ctl", 6'h00, init_ctl)
  endtask : t_por
  task automatic t_wdt;
    int n;
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(posedge clk);
    `CHK("pdf", 1'b1, pdf_flag)
    pd <= 1'b1;
    wdt_fire <= 1'b1;
    @(posedge clk);
    wdt_fire <= 1'b0;
    for (n = 0; n < 6 && pc_sp !== 1'b1; n++) @(posedge clk);
    `CHK("pc_sp", 1'b1, pc_sp)
    @(posedge clk);
    `CHK("to", 2'b11, {to_flag, pdf_flag})
    `CHK("no_rst", 1'b0, sys_rst)
    clr <= 1'b1;
    pd <= 1'b0;
    @(posedge clk);
    clr <= 1'b0;
    wdt_fire <= 1'b1;
    @(posedge clk);
    `CHK("clr", 2'b00, {to_flag, pdf_flag})
    wdt_fire <= 1'b0;
    chk_rst(8, 1'b1);
    `CHK("to_run", 2'b10, {to_flag, pdf_flag})
    wr(ADDR_WDTEN, WDT_DIS);
    rd("wdten", ADDR_WDTEN, 32'h15);
    `CHK("wdt_en", 1'b0, wdt_en)
  endtask : t_wdt
  task automatic t_pin;
    pin_low <= 1'b1;
    chk_rst(10, 1'b0);
    pin_low <= 1'b0;
    wr(ADDR_CTRL_WORD, CTRL_PIN);
    rd("ctrl_word", ADDR_CTRL_WORD, 32'hAA);
    `CHK("pin_mode", 1'b1, pin_is_rst)
    pin_low <= 1'b1;
    chk_rst(12, 1'b1);
    rd("ctrl_word", ADDR_CTRL_WORD, 32'h55);
    `CHK("to_kept", 1'b1, to_flag)
  endtask : t_pin
  task automatic t_cfg;
    logic [7:0] ad [3] = '{ADDR_CTRL_WORD, ADDR_LVSEL, ADDR_WDTEN};
    logic [31:0] bt [3] = '{32'h8, 32'h2, 32'h1};
    logic [31:0] pv [3] = '{32'h55, 32'h55, 32'h0A};
    int i;
    wr(ADDR_MASK, 32'h8);
    for (i = 0; i < 3; i++) begin
      wr(ad[i], 32'h12);
      chk_rst(20, 1'b1);
      rd("reload", ad[i], pv[i]);
      wr(ADDR_FLAGS, 32'h0);
      rd("cause", ADDR_FLAGS, bt[i]);
      `CHK("irq", i == 0, irq)
      wr(ADDR_FLAGS, bt[i]);
      rd("cleared", ADDR_FLAGS, 32'h0);
      `CHK("irq_off", 1'b0, irq)
    end
  endtask : t_cfg
  task automatic t_lv;
    int i;
    for (i = 0; i < 4; i++) begin
      wr(ADDR_LVSEL, lvc[i]);
      rd("lvsel", ADDR_LVSEL, lvc[i]);
      `CHK("level", 2'(i), lv_level)
    end
    wr(ADDR_LVSEL, LVS_3V15);
    lv_low <= 1'b1;
    repeat (2) @(posedge clk);
    lv_low <= 1'b0;
    chk_rst(12, 1'b0);
    lv_low <= 1'b1;
    chk_rst(20, 1'b1);
    rd("lv_flag", ADDR_FLAGS, 32'h4);
    rd("lv_kept", ADDR_LVSEL, 32'h99);
    wr(ADDR_FLAGS, 32'h4);
    pd <= 1'b1;
    lv_low <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("lvr_en", 1'b0, lvr_en)
    chk_rst(12, 1'b0);
    lv_low <= 1'b0;
    repeat (6) @(posedge clk);
    pd <= 1'b0;
  endtask : t_lv
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    `CHK("init_rst", 6'h3F, init_ctl)
    rst_n <= 1'b1;
    t_por();
    t_wdt();
    t_pin();
    t_cfg();
    t_lv();
    report_and_stop();
  end
endmodule : reset_source_control_tb
